// ---- vpc_pkg.sv ----
// Purpose: Shared constants, types and arithmetic for the valve position PI core.
// Assumes: Positions, commands and drive are unsigned counts of 0.01 percent.
// Notes:   Proportional gains and gain slope are counts of 0.01, integral gain of 0.001; the integrator is in 0.01 percent.
`default_nettype none

package vpc_pkg;

    // ==================================================================
    // Timing
    localparam int CLK_MHZ    = 250;
    localparam int BLINK_MS   = 250;
    localparam int SETTLE_MS  = 1000;
    localparam int SPAN_MS    = 3000;
    localparam int BLINK_CYC  = BLINK_MS * 1000 * CLK_MHZ;
    localparam int SETTLE_CYC = SETTLE_MS * 1000 * CLK_MHZ;
    localparam int SPAN_CYC   = SPAN_MS * 1000 * CLK_MHZ;

    // ==================================================================
    // Scales and limits
    localparam logic [15:0] PCT_FULL     = 16'h2710;
    localparam logic [15:0] PCT_HALF     = 16'h1388;
    localparam logic [15:0] INTEG_LO_POS = 16'h012C;
    localparam logic [15:0] INTEG_HI_POS = 16'h25E4;
    localparam logic [15:0] MOVE_MIN     = 16'h0064;
    localparam int          INTEG_LIM    = 2000;
    localparam int          SCALE        = 100;
    localparam int          INT_DIV      = 1000;

    // ==================================================================
    // Reset and factory values
    localparam logic [15:0] GAIN_MAX_RST   = 16'h00C8;
    localparam logic [15:0] GAIN_MIN_RST   = 16'h0064;
    localparam logic [15:0] GAIN_SLOPE_RST = 16'h0005;
    localparam logic [15:0] INTEGRAL_GAIN_RST      = 16'h000A;
    localparam logic [15:0] OFFSET_RST     = 16'h1388;

    // ==================================================================
    // Version blink code
    localparam int          VER_W0     = 9;
    localparam int          VER_W1     = 3;
    localparam int          VER_BASE   = 3;
    localparam logic [1:0]  COL_GREEN  = 2'h0;
    localparam logic [1:0]  COL_YELLOW = 2'h1;
    localparam logic [1:0]  COL_RED    = 2'h2;
    localparam logic [2:0]  SLOT_LAST  = 3'h7;

    typedef enum logic [2:0] {
        CS_IDLE        = 3'h0,
        CS_CLOSE       = 3'h1,
        CS_OPEN        = 3'h2,
        CS_NULL        = 3'h3,
        CS_HOLD_CLOSED = 3'h4,
        CS_HOLD_OPEN   = 3'h5
    } vpc_cal_t;

    function automatic logic signed [31:0] vpc_sat(input logic signed [31:0] x,
                                                   input logic signed [31:0] lo,
                                                   input logic signed [31:0] hi);
        vpc_sat = (x < lo) ? lo : ((x > hi) ? hi : x);
    endfunction

    function automatic logic signed [31:0] vpc_abs(input logic signed [31:0] x);
        vpc_abs = (x < 0) ? -x : x;
    endfunction

    function automatic logic signed [31:0] vpc_ext(input logic [15:0] x);
        vpc_ext = $signed({16'h0000, x});
    endfunction

endpackage

`default_nettype wire

// ---- vpc_blink.sv ----
// Purpose: Plays one version field as three coloured blinks and a pause.
// Assumes: Field value is 0 to 26; show is a level from the jog buttons.
// Notes:   Sequence restarts from the first blink each time show rises.
`timescale 1ns/1ns
`default_nettype none

module vpc_blink #(
    parameter int BLINK_CYC = vpc_pkg::BLINK_CYC
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       show,
    input  wire logic [4:0] value,
    output logic            led_green,
    output logic            led_yellow,
    output logic            led_red
);

    // ==================================================================
    // Base-three digits of the field
    function automatic logic [1:0] vpc_digit(input logic [4:0] v, input logic [1:0] idx);
        int d;
        d = 0;
        unique case (idx)
            2'h0:    d = int'(v) / vpc_pkg::VER_W0;
            2'h1:    d = (int'(v) / vpc_pkg::VER_W1) % vpc_pkg::VER_BASE;
            default: d = int'(v) % vpc_pkg::VER_BASE;
        endcase
        vpc_digit = d[1:0];
    endfunction

    logic [31:0] cnt_q;
    logic [2:0]  slot_q;
    wire         slot_end = (cnt_q == 32'(BLINK_CYC - 1));
    wire         lit      = show && !slot_q[0] && (slot_q[2:1] != 2'h3);
    wire  [1:0]  colour   = vpc_digit(value, slot_q[2:1]);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= 32'h0000_0000;
            slot_q <= 3'h0;
        end else if (!show) begin
            cnt_q  <= 32'h0000_0000;
            slot_q <= 3'h0;
        end else if (slot_end) begin
            cnt_q  <= 32'h0000_0000;
            slot_q <= (slot_q == vpc_pkg::SLOT_LAST) ? 3'h0 : slot_q + 3'h1;
        end else begin
            cnt_q  <= cnt_q + 32'h0000_0001;
        end
    end

    assign led_green  = lit && (colour == vpc_pkg::COL_GREEN);
    assign led_yellow = lit && (colour == vpc_pkg::COL_YELLOW);
    assign led_red    = lit && (colour == vpc_pkg::COL_RED);

endmodule

`default_nettype wire

// ---- vpc_control.sv ----
// Purpose: Valve position PI core with stroke calibration, fault flags and LEDs.
// Assumes: pos_valid marks a fresh stem sample; all inputs synchronous to mclk.
// Notes:   The control loop updates only on samples; the close and open calibration phases force drive.
`timescale 1ns/1ns
`default_nettype none

module vpc_control #(
    parameter int BLINK_CYC  = vpc_pkg::BLINK_CYC,
    parameter int SETTLE_CYC = vpc_pkg::SETTLE_CYC,
    parameter int SPAN_CYC   = vpc_pkg::SPAN_CYC,
    parameter logic [4:0] VER_MAJOR = 5'h01,   // Arbitrary value
    parameter logic [4:0] VER_MINOR = 5'h00    // Arbitrary value
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [15:0] cmd_pct,
    input  wire logic [15:0] pos_pct,
    input  wire logic        pos_valid,
    input  wire logic        sensor_low_oor,
    input  wire logic        sensor_high_oor,
    input  wire logic        cal_start,
    input  wire logic        jog_up,
    input  wire logic        jog_down,
    input  wire logic        param_wr,
    input  wire logic [15:0] gain_max_in,
    input  wire logic [15:0] gain_min_in,
    input  wire logic [15:0] gain_slope_in,
    input  wire logic [15:0] integral_gain_in,
    input  wire logic        offset_wr,
    input  wire logic [15:0] offset_in,
    input  wire logic        load_factory_defaults,
    output logic [15:0]      drive_pct,
    output logic [15:0]      integ_acc,
    output logic [15:0]      spool_null_offset,
    output logic             cal_active,
    output logic             cal_closed_flag,
    output logic             cal_open_flag,
    output logic             cal_span_flag,
    output logic             led_green,
    output logic             led_yellow,
    output logic             led_red
);

    // ==================================================================
    // Reset release
    logic [1:0] rst_sync_q;
    wire        rst_n = rst_sync_q[1];

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) rst_sync_q <= 2'h0;
        else          rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // ==================================================================
    // Tuning parameters
    logic [15:0] gain_max_q, gain_min_q, gain_slope_q, ig_q, offset_q;
    logic signed [15:0] acc_q;
    vpc_pkg::vpc_cal_t  cal_q, cal_d;
    logic [31:0] tmr_q;
    logic [15:0] mark_q, drive_q;
    logic [2:0]  flags_q, seen_q;
    logic        moved_q, phase_q;
    logic [31:0] led_cnt_q;
    logic [2:0]  led_q;

    wire in_open   = (cal_q == vpc_pkg::CS_OPEN);
    wire in_close  = (cal_q == vpc_pkg::CS_CLOSE);
    wire in_null   = (cal_q == vpc_pkg::CS_NULL);
    wire hold_cl   = (cal_q == vpc_pkg::CS_HOLD_CLOSED);
    wire hold_op   = (cal_q == vpc_pkg::CS_HOLD_OPEN);
    wire idle      = (cal_q == vpc_pkg::CS_IDLE);
    wire tmr_done  = (tmr_q == 32'h0000_0000);
    wire low_hit   = in_close && sensor_low_oor;
    wire high_hit  = in_open && sensor_high_oor;
    wire moved_now = moved_q || (pos_valid && (pos_pct > mark_q + vpc_pkg::MOVE_MIN));
    wire span_end  = in_open && !sensor_high_oor && tmr_done;
    wire null_end  = in_null && tmr_done;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gain_max_q   <= vpc_pkg::GAIN_MAX_RST;
            gain_min_q   <= vpc_pkg::GAIN_MIN_RST;
            gain_slope_q <= vpc_pkg::GAIN_SLOPE_RST;
            ig_q         <= vpc_pkg::INTEGRAL_GAIN_RST;
        end else if (load_factory_defaults) begin
            gain_max_q   <= vpc_pkg::GAIN_MAX_RST;
            gain_min_q   <= vpc_pkg::GAIN_MIN_RST;
            gain_slope_q <= vpc_pkg::GAIN_SLOPE_RST;
            ig_q         <= vpc_pkg::INTEGRAL_GAIN_RST;
        end else if (param_wr) begin
            gain_max_q   <= gain_max_in;
            gain_min_q   <= gain_min_in;
            gain_slope_q <= gain_slope_in;
            ig_q         <= integral_gain_in;
        end
    end

    // ==================================================================
    // PI arithmetic
    wire [15:0] cmd_eff  = in_null ? vpc_pkg::PCT_HALF : cmd_pct;
    wire signed [31:0] dev    = vpc_pkg::vpc_ext(cmd_eff) - vpc_pkg::vpc_ext(pos_pct);
    wire signed [31:0] red    = (vpc_pkg::vpc_abs(dev) * vpc_pkg::vpc_ext(gain_slope_q))
                                / vpc_pkg::SCALE;
    wire signed [31:0] graw   = vpc_pkg::vpc_ext(gain_max_q) - red;
    wire signed [31:0] pgain  = (graw < vpc_pkg::vpc_ext(gain_min_q)) ?
                                vpc_pkg::vpc_ext(gain_min_q) : graw;
    wire signed [31:0] pterm  = (pgain * dev) / vpc_pkg::SCALE;
    wire signed [31:0] step   = (dev * vpc_pkg::vpc_ext(ig_q)) / vpc_pkg::INT_DIV;
    wire signed [31:0] acc32  = {{16{acc_q[15]}}, acc_q};
    wire signed [31:0] acc_nx = vpc_pkg::vpc_sat(acc32 + step, -vpc_pkg::INTEG_LIM,
                                                 vpc_pkg::INTEG_LIM);
    // Windup near the ends comes from seat or pressure shifts, so freeze there
    wire        integ_ok = (pos_pct >= vpc_pkg::INTEG_LO_POS) &&
                           (pos_pct <= vpc_pkg::INTEG_HI_POS);
    wire        loop_on  = idle || in_null;
    wire signed [31:0] sum = vpc_pkg::vpc_sat(pterm + acc32 + vpc_pkg::vpc_ext(offset_q),
                                              0, vpc_pkg::vpc_ext(vpc_pkg::PCT_FULL));
    wire signed [31:0] off_nx = vpc_pkg::vpc_sat(vpc_pkg::vpc_ext(offset_q) + acc32,
                                                 0, vpc_pkg::vpc_ext(vpc_pkg::PCT_FULL));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)                                   acc_q <= 16'h0000;
        else if (ig_q == 16'h0000 || null_end)        acc_q <= 16'h0000;
        else if (loop_on && pos_valid && integ_ok)    acc_q <= acc_nx[15:0];
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)         offset_q <= vpc_pkg::OFFSET_RST;
        else if (null_end)  offset_q <= off_nx[15:0];
        else if (offset_wr) offset_q <= offset_in;
    end

    // The close and open calibration phases force the stem to an end regardless of the loop
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)                    drive_q <= 16'h0000;
        else if (in_close || hold_cl)  drive_q <= 16'h0000;
        else if (in_open || hold_op)   drive_q <= vpc_pkg::PCT_FULL;
        else if (pos_valid)            drive_q <= sum[15:0];
    end

    // ==================================================================
    // Stroke calibration
    always_comb begin
        cal_d = cal_q;
        unique case (cal_q)
            vpc_pkg::CS_IDLE:        if (cal_start) cal_d = vpc_pkg::CS_CLOSE;
            vpc_pkg::CS_CLOSE:       if (low_hit) cal_d = vpc_pkg::CS_HOLD_CLOSED;
                                     else if (tmr_done) cal_d = vpc_pkg::CS_OPEN;
            vpc_pkg::CS_OPEN:        if (high_hit) cal_d = vpc_pkg::CS_HOLD_OPEN;
                                     else if (span_end) cal_d = moved_now ?
                                         vpc_pkg::CS_NULL : vpc_pkg::CS_IDLE;
            vpc_pkg::CS_NULL:        if (null_end) cal_d = vpc_pkg::CS_IDLE;
            vpc_pkg::CS_HOLD_CLOSED,
            vpc_pkg::CS_HOLD_OPEN:   if (cal_start) cal_d = vpc_pkg::CS_CLOSE;
            default:                 cal_d = vpc_pkg::CS_IDLE;
        endcase
    end

    wire cal_enter = (cal_d == vpc_pkg::CS_CLOSE) && (cal_q != vpc_pkg::CS_CLOSE);
    wire span_err  = span_end && !moved_now && !high_hit;
    wire [2:0] seen_nx = seen_q | {span_err, high_hit, low_hit};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cal_q   <= vpc_pkg::CS_IDLE;
            tmr_q   <= 32'h0000_0000;
            mark_q  <= 16'h0000;
            moved_q <= 1'b0;
            seen_q  <= 3'h0;
            flags_q <= 3'h0;
        end else begin
            cal_q  <= cal_d;
            seen_q <= cal_enter ? 3'h0 : seen_nx;
            if (cal_enter)                        tmr_q <= 32'(SETTLE_CYC);
            else if (in_close && tmr_done)        tmr_q <= 32'(SPAN_CYC);
            else if (span_end)                    tmr_q <= 32'(SETTLE_CYC);
            else if (!tmr_done)                   tmr_q <= tmr_q - 32'h0000_0001;
            if (in_close) mark_q <= pos_pct;
            moved_q <= in_open && moved_now;
            // Faults set at once; a finished run replaces them with its own result
            if ((span_end && !moved_now) || null_end) flags_q <= seen_nx;
            else                                      flags_q <= flags_q | seen_nx;
        end
    end

    // ==================================================================
    // LEDs
    wire ver_show = (jog_up || jog_down) && idle;
    wire [4:0] ver_val = jog_up ? VER_MAJOR : VER_MINOR;
    wire ver_g, ver_y, ver_r;

    vpc_blink #(.BLINK_CYC(BLINK_CYC)) u_blink (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .show       (ver_show),
        .value      (ver_val),
        .led_green  (ver_g),
        .led_yellow (ver_y),
        .led_red    (ver_r)
    );

    wire hold_red = (hold_cl && sensor_low_oor) || (hold_op && sensor_high_oor);
    wire hold_yel = (hold_cl || hold_op) && !hold_red;
    wire fault    = idle && (flags_q != 3'h0);
    wire base_r   = phase_q && (hold_red || fault);
    wire base_y   = phase_q && hold_yel;
    wire base_g   = phase_q && !hold_red && !hold_yel && !fault;
    // Only the LED pattern is swapped; the loop never sees the jog buttons
    wire [2:0] led_d = ver_show ? {ver_r, ver_y, ver_g} : {base_r, base_y, base_g};

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            led_cnt_q <= 32'h0000_0000;
            phase_q   <= 1'b0;
            led_q     <= 3'h0;
        end else begin
            led_q <= led_d;
            if (led_cnt_q == 32'(BLINK_CYC - 1)) begin
                led_cnt_q <= 32'h0000_0000;
                phase_q   <= !phase_q;
            end else begin
                led_cnt_q <= led_cnt_q + 32'h0000_0001;
            end
        end
    end

    assign drive_pct         = drive_q;
    assign integ_acc         = acc_q;
    assign spool_null_offset = offset_q;
    assign cal_active        = !idle;
    assign cal_closed_flag   = flags_q[0];
    assign cal_open_flag     = flags_q[1];
    assign cal_span_flag     = flags_q[2];
    assign led_green         = led_q[0];
    assign led_yellow        = led_q[1];
    assign led_red           = led_q[2];

    // ==================================================================
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Version digits must never leak onto the LEDs while a calibration runs
    ver_block_a: assert property ((!idle && !hold_red) |=> !led_red)
        else $error("version shown in cal");
    closed_hold_a: assert property (hold_cl |=> drive_q == 16'h0000)
        else $error("closed hold not at zero");
    closed_flag_a: assert property (low_hit |=> cal_closed_flag && hold_cl)
        else $error("closed-end fault not raised");
    open_hold_a: assert property (hold_op |=> drive_q == vpc_pkg::PCT_FULL)
        else $error("open hold not at full");
    yellow_back_a: assert property ((hold_cl && !sensor_low_oor && !ver_show) |=> !led_red)
        else $error("red shown while back in range");
    span_flag_a: assert property (span_err |=> cal_span_flag && idle)
        else $error("span fault not raised");
    gain_floor_a: assert property (pgain >= vpc_pkg::vpc_ext(gain_min_q))
        else $error("gain below minimum");
    defaults_a: assert property (load_factory_defaults |=> gain_max_q == 16'h00C8
        && gain_min_q == 16'h0064 && gain_slope_q == 16'h0005 && ig_q == 16'h000A)
        else $error("factory defaults not loaded");
    integ_stop_a: assert property ((pos_valid && !integ_ok && ig_q != 16'h0000
        && !null_end) |=> $stable(acc_q)) else $error("integrated outside band");
    acc_clamp_a: assert property ($signed(acc_q) <= 2000 && $signed(acc_q) >= -2000)
        else $error("integrator past clamp");
    integral_gain_zero_a: assert property (ig_q == 16'h0000 |=> acc_q == 16'h0000)
        else $error("integrator not cleared");
    offset_store_a: assert property (null_end |=>
        vpc_pkg::vpc_ext(spool_null_offset) == $past(off_nx))
        else $error("null offset not stored");
    drive_range_a: assert property (drive_q <= vpc_pkg::PCT_FULL)
        else $error("drive out of range");

endmodule

`default_nettype wire

// ---- vpc_valve_model.sv ----
// Purpose: Behavioural valve, stem sensor and spool driver around the core.
// Assumes: Stem follows the drive one cycle late unless stuck.
// Notes:   Outside calibration the bench hands in every stem sample itself.
`timescale 1ns/1ns
`default_nettype none

module vpc_valve_model (
    input  wire logic        mclk,
    input  wire logic        cal_active,
    input  wire logic [15:0] drive_pct,
    input  wire logic        stuck,
    input  wire logic        low_bad,
    input  wire logic        high_bad,
    input  wire logic        smp_req,
    input  wire logic [15:0] smp_pos,
    output logic [15:0]      pos_pct,
    output logic             pos_valid,
    output logic             sensor_low_oor,
    output logic             sensor_high_oor
);
    logic [1:0]  tick_q = 2'h0;
    logic [15:0] stem_q = 16'h1388;

    // ==================================================================
    // Stem motion; a stuck stem models a dead spool or no supply
    always_ff @(posedge mclk) begin
        tick_q <= tick_q + 2'h1;
        stem_q <= stuck ? stem_q : drive_pct;
    end

    // Sensor drops out of range only near the badly linked end
    assign pos_pct         = cal_active ? stem_q : smp_pos;
    assign pos_valid       = cal_active ? (tick_q == 2'h3) : smp_req;
    assign sensor_low_oor  = low_bad && (pos_pct < 16'h0064);
    assign sensor_high_oor = high_bad && (pos_pct > 16'h26AC);
endmodule

`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the valve position PI core.
// Assumes: Shortened timing parameters; fixed seed for repeatable runs.
// Notes:   Loop expectations come from a bench model of gain, integrator and sum.
`timescale 1ns/1ns
`default_nettype none

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end

module testbench;
    logic        mclk = 1'b0, reset_n = 1'b0, smp_req = 1'b0, stuck = 1'b0;
    logic        low_bad = 1'b0, high_bad = 1'b0, cal_start = 1'b0, param_wr = 1'b0;
    logic        jog_up = 1'b0, jog_down = 1'b0, offset_wr = 1'b0, load_factory_defaults = 1'b0;
    logic [15:0] cmd_pct = 16'h0000, smp_pos = 16'h0000, offset_in = 16'h0000;
    logic [15:0] gain_max_in = 16'h00C8, gain_min_in = 16'h0064;
    logic [15:0] gain_slope_in = 16'h0005, integral_gain_in = 16'h000A;
    logic [15:0] pos_pct, drive_pct, integ_acc, spool_null_offset;
    logic        pos_valid, sensor_low_oor, sensor_high_oor, cal_active;
    logic        cal_closed_flag, cal_open_flag, cal_span_flag, led_green, led_yellow, led_red;
    int          seed = 54, err_count = 0, checked = 0;
    int          gm = 200, gn = 100, sl = 5, ig = 10, acc = 0, off = 5000, drv = 0;

    always #2 mclk = ~mclk;

    vpc_control #(.BLINK_CYC(4), .SETTLE_CYC(8), .SPAN_CYC(16),
                  .VER_MAJOR(5'h13), .VER_MINOR(5'h0E)) DUT (
        .mclk(mclk), .reset_n(reset_n), .cmd_pct(cmd_pct), .pos_pct(pos_pct),
        .pos_valid(pos_valid), .sensor_low_oor(sensor_low_oor),
        .sensor_high_oor(sensor_high_oor), .cal_start(cal_start), .jog_up(jog_up),
        .jog_down(jog_down), .param_wr(param_wr), .gain_max_in(gain_max_in),
        .gain_min_in(gain_min_in), .gain_slope_in(gain_slope_in),
        .integral_gain_in(integral_gain_in), .offset_wr(offset_wr), .offset_in(offset_in),
        .load_factory_defaults(load_factory_defaults), .drive_pct(drive_pct),
        .integ_acc(integ_acc), .spool_null_offset(spool_null_offset),
        .cal_active(cal_active), .cal_closed_flag(cal_closed_flag),
        .cal_open_flag(cal_open_flag), .cal_span_flag(cal_span_flag),
        .led_green(led_green), .led_yellow(led_yellow), .led_red(led_red));

    vpc_valve_model valve (
        .mclk(mclk), .cal_active(cal_active), .drive_pct(drive_pct), .stuck(stuck),
        .low_bad(low_bad), .high_bad(high_bad), .smp_req(smp_req), .smp_pos(smp_pos),
        .pos_pct(pos_pct), .pos_valid(pos_valid), .sensor_low_oor(sensor_low_oor),
        .sensor_high_oor(sensor_high_oor));

    // ==================================================================
    // Reference model and drivers
    function automatic int sat(int x, int lo, int hi);
        return (x < lo) ? lo : ((x > hi) ? hi : x);
    endfunction

    function automatic int rnd(int n);
        return int'($unsigned($random(seed)) % n);
    endfunction

    function automatic void model(int cmd, int pos);
        int dev, g;
        dev = cmd - pos;
        g = gm - ((dev < 0) ? -dev : dev) * sl / 100;
        if (g < gn) g = gn;
        // Drive sums the integrator as it stood before this sample
        drv = sat(g * dev / 100 + acc + off, 0, 10000);
        if (ig == 0) acc = 0;
        else if (pos >= 300 && pos <= 9700) acc = sat(acc + dev * ig / 1000, -2000, 2000);
    endfunction

    // Expected {red, yellow, green} for one slot of a version field
    function automatic logic [2:0] ver_led(int v, int k);
        int w, d;
        if (k % 2 == 1 || k > 5) return 3'h0;
        w = (k == 0) ? 9 : ((k == 2) ? 3 : 1);
        d = (v / w) % 3;
        return (d == 0) ? 3'h1 : ((d == 1) ? 3'h2 : 3'h4);
    endfunction

    task automatic show_ver(logic up, int v);
        @(posedge mclk);
        {jog_up, jog_down} <= 2'h0;
        @(posedge mclk);
        {jog_up, jog_down} <= {up, !up};
        @(posedge mclk);
        for (int k = 0; k < 8; k++) begin
            @(posedge mclk);
            #1;
            `CHK({led_red, led_yellow, led_green}, ver_led(v, k))
            repeat (3) @(posedge mclk);
        end
        {jog_up, jog_down} <= 2'h0;
    endtask

    // Colours seen over more than one blink period
    task automatic leds(logic [2:0] exp);
        logic [2:0] s;
        s = 3'h0;
        repeat (10) begin
            @(posedge mclk);
            #1;
            s |= {led_red, led_yellow, led_green};
        end
        `CHK(s, exp)
    endtask

    // Jog is scrambled on every sample: the loop must not notice
    task automatic sample(int cmd, int pos);
        @(posedge mclk);
        cmd_pct <= 16'(cmd);
        smp_pos <= 16'(pos);
        smp_req <= 1'b1;
        jog_up <= 1'($random(seed));
        jog_down <= 1'($random(seed));
        @(posedge mclk);
        smp_req <= 1'b0;
        model(cmd, pos);
        @(posedge mclk);
        #1;
        `CHK(drive_pct, 16'(drv))
        `CHK(integ_acc, 16'(acc))
    endtask

    task automatic gains(int a, int b, int c, int d);
        @(posedge mclk);
        {gain_max_in, gain_min_in, gain_slope_in, integral_gain_in} <= {16'(a), 16'(b), 16'(c), 16'(d)};
        param_wr <= 1'b1;
        @(posedge mclk);
        param_wr <= 1'b0;
        {gm, gn, sl, ig} = {a, b, c, d};
        @(posedge mclk);
        #1;
        if (d == 0) acc = 0;
        `CHK(integ_acc, 16'(acc))
    endtask

    task automatic run_cal(int lim);
        int n;
        @(posedge mclk);
        cal_start <= 1'b1;
        @(posedge mclk);
        cal_start <= 1'b0;
        #1;
        for (n = 0; n < lim && cal_active !== 1'b0; n++) begin
            @(posedge mclk);
            #1;
        end
    endtask

    task automatic give_verdict;
        if (err_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        give_verdict();
    end

    // ==================================================================
    // Scenarios
    initial begin
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
        repeat (4) @(posedge mclk);
        sample(10000, 299);
        sample(10000, 300);
        sample(0, 9701);
        repeat (25) sample(10000, 300);
        repeat (45) sample(0, 9700);
        gains(gm, gn, sl, 0);
        gains(200, 100, 5, 10);
        for (int i = 0; i < 60; i++) begin
            if (i % 15 == 14) gains(100 + rnd(300), 30 + rnd(70), rnd(20), 1 + rnd(40));
            sample(rnd(10001), rnd(10001));
        end
        @(posedge mclk);
        load_factory_defaults <= 1'b1;
        @(posedge mclk);
        load_factory_defaults <= 1'b0;
        {gm, gn, sl, ig} = {200, 100, 5, 10};
        repeat (10) sample(rnd(10001), rnd(10001));
        stuck <= 1'b1;
        run_cal(200);
        `CHK({cal_active, cal_span_flag}, 2'h1)
        stuck <= 1'b0;
        low_bad <= 1'b1;
        run_cal(40);
        `CHK({cal_closed_flag, cal_span_flag, drive_pct}, {2'h3, 16'h0000})
        leds(3'h4);
        low_bad <= 1'b0;
        leds(3'h2);
        run_cal(200);
        `CHK({cal_closed_flag, cal_open_flag, cal_span_flag, integ_acc}, 19'h0)
        high_bad <= 1'b1;
        run_cal(60);
        `CHK({cal_open_flag, drive_pct}, {1'b1, 16'h2710})
        leds(3'h4);
        high_bad <= 1'b0;
        leds(3'h2);
        run_cal(200);
        show_ver(1'b1, 19);
        show_ver(1'b0, 14);
        gains(200, 100, 5, 0);
        off = 2000 + rnd(6000);
        @(posedge mclk);
        offset_in <= 16'(off);
        offset_wr <= 1'b1;
        @(posedge mclk);
        offset_wr <= 1'b0;
        @(posedge mclk);
        #1;
        `CHK(spool_null_offset, 16'(off))
        gains(200, 100, 5, 10);
        repeat (20) sample(rnd(10001), rnd(10001));
        give_verdict();
    end
endmodule

`default_nettype wire
